// ### rtl/bal_alu.sv
// Byte arithmetic and logic unit: executes one operation per request
// and returns the result with its updated flag vector.
// Assumes the decoder holds off new requests while busy_o is high.
//
// Function
// [RULE1] Add registers, optional carry, one clock
// [RULE2] Word add immediate, Z C N V S, two clocks
// [RULE3] Subtract register or constant, one clock
// [RULE4] Subtract with borrow, one clock
// [RULE5] Word subtract immediate, two clocks
// [RULE6] AND writes Z N V only
// [RULE7] OR and XOR update Z N V
// [RULE8] Set mask bits by OR
// [RULE9] Z from zero result, N msb, V cleared
// [RULE10] Complements with carry update, one clock
`timescale 1ns/1ps

module bal_alu
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire bal_pkg::bal_op_t op_i,
    input wire logic [7:0] dst_i,
    input wire logic [7:0] dst_high_i,
    input wire logic [7:0] src_i,
    input wire logic [7:0] flags_i,
    output logic [7:0] result_o,
    output logic [7:0] result_high_o,
    output logic [7:0] flags_o,
    output logic done_o,
    output logic word_o,
    output logic busy_o
);
    import bal_pkg::*;

    typedef enum logic {BAL_IDLE, BAL_WORD_HIGH} bal_state_t;

    bal_state_t state_reg;
    bal_op_t op_reg;
    logic [7:0] result_next;
    logic [7:0] flags_next;
    logic [8:0] wide;
    logic [4:0] nib;
    logic cin;
    logic [7:0] a;
    logic [7:0] b;
    logic sub;
    logic [7:0] hold_high;
    logic hold_carry;
    logic [7:0] high_sum;
    logic high_borrow;
    logic [8:0] high_wide;
    logic [7:0] low_saved;
    logic [7:0] flags_saved;
    logic [7:0] src_high_orig;

    // All checks below sample on the core clock and sleep through reset
    default clocking cb_core @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // ============================================================
    // Helper: subtract op check, used for both byte and word paths
    function automatic logic is_sub(input bal_op_t op);
        is_sub = op inside {BAL_OP_DIFFERENCE_REGS,
            BAL_OP_DIFFERENCE_CONST, BAL_OP_BORROW_DIFFERENCE_REGS,
            BAL_OP_BORROW_DIFFERENCE_CONST,
            BAL_OP_WORD_IMMEDIATE_DIFFERENCE, BAL_OP_TWOS_COMPLEMENT};
    endfunction

    // Word-pair op check, shared by stage load, sequencer and outputs
    function automatic logic is_word_op(input bal_op_t op);
        is_word_op = op inside {BAL_OP_WORD_IMMEDIATE_SUM,
            BAL_OP_WORD_IMMEDIATE_DIFFERENCE};
    endfunction

    // ============================================================
    // Operand selection and adder for the byte (low) step
    always_comb
    begin
        sub = is_sub(op_i);
        a = dst_i;
        b = src_i;
        cin = 1'b0;
        case (op_i)
            BAL_OP_CARRY_SUM_REGS,
            BAL_OP_BORROW_DIFFERENCE_REGS,
            BAL_OP_BORROW_DIFFERENCE_CONST: cin = flags_i[BAL_FLAG_C];
            // [RULE10] two's complement as zero minus operand
            BAL_OP_TWOS_COMPLEMENT:
            begin
                a = 8'h00;
                b = dst_i;
            end
            default: cin = 1'b0;
        endcase
        if (sub)
        begin
            wide = {1'b0, a} - {1'b0, b} - {8'h00, cin};
            nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
        end
        else
        begin
            wide = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        end
    end

    // ============================================================
    // Result and flag selection for the first clock
    always_comb
    begin
        result_next = wide[7:0];
        flags_next = flags_i;
        case (op_i)
            // [RULE1] add with optional carry, Z C N V H
            // [RULE3] subtract register or constant
            // [RULE4] borrow subtract keeps Z when result is zero
            BAL_OP_SUM_REGS, BAL_OP_CARRY_SUM_REGS,
            BAL_OP_DIFFERENCE_REGS, BAL_OP_DIFFERENCE_CONST,
            BAL_OP_BORROW_DIFFERENCE_REGS, BAL_OP_BORROW_DIFFERENCE_CONST,
            BAL_OP_TWOS_COMPLEMENT:
            begin
                flags_next[BAL_FLAG_C] = wide[8];
                flags_next[BAL_FLAG_H] = nib[4];
                flags_next[BAL_FLAG_N] = wide[7];
                if (sub)
                    flags_next[BAL_FLAG_V] = (a[7] ^ b[7]) & (a[7] ^ wide[7]);
                else
                    flags_next[BAL_FLAG_V] = ~(a[7] ^ b[7]) & (a[7] ^ wide[7]);
                if (op_i == BAL_OP_BORROW_DIFFERENCE_REGS ||
                    op_i == BAL_OP_BORROW_DIFFERENCE_CONST)
                    flags_next[BAL_FLAG_Z] = (wide[7:0] == 8'h00) &
                        flags_i[BAL_FLAG_Z];
                else
                    flags_next[BAL_FLAG_Z] = (wide[7:0] == 8'h00);
            end
            // [RULE6] AND updates only Z N V
            BAL_OP_CONJ_REGS, BAL_OP_BITWISE_CONJ_CONST:
                result_next = dst_i & src_i;
            // [RULE7] OR and XOR of operands
            BAL_OP_DISJ_REGS, BAL_OP_BITWISE_DISJ_CONST:
                result_next = dst_i | src_i;
            BAL_OP_BITWISE_XOR_REGS:
                result_next = dst_i ^ src_i;
            // [RULE8] set bits selected by mask
            BAL_OP_SET_BITS_MASK:
                result_next = dst_i | src_i;
            // [RULE10] one's complement sets carry
            BAL_OP_ONES_COMPLEMENT:
            begin
                result_next = 8'hFF - dst_i;
                flags_next[BAL_FLAG_C] = 1'b1;
            end
            default: result_next = wide[7:0];
        endcase
        // [RULE9] logical ops: Z from zero, N msb, V cleared
        if (op_i inside {BAL_OP_CONJ_REGS, BAL_OP_BITWISE_CONJ_CONST,
            BAL_OP_DISJ_REGS, BAL_OP_BITWISE_DISJ_CONST,
            BAL_OP_BITWISE_XOR_REGS, BAL_OP_SET_BITS_MASK,
            BAL_OP_ONES_COMPLEMENT})
        begin
            flags_next[BAL_FLAG_Z] = (result_next == 8'h00);
            flags_next[BAL_FLAG_N] = result_next[7];
            flags_next[BAL_FLAG_V] = 1'b0;
        end
    end

    // ============================================================
    // Second clock of a word op: high byte absorbs the low carry
    assign src_high_orig = hold_high;
    always_comb
    begin
        if (is_sub(op_reg))
            high_wide = {1'b0, src_high_orig} - {8'h00, hold_carry};
        else
            high_wide = {1'b0, src_high_orig} + {8'h00, hold_carry};
        high_sum = high_wide[7:0];
        high_borrow = high_wide[8];
    end

    // The high byte and low carry are parked in the word stage
    bal_word_stage u_word_stage
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .load_i(start_i && !busy_o && is_word_op(op_i)),
        .high_i(dst_high_i),
        .carry_i(wide[8]),
        .high_o(hold_high),
        .carry_o(hold_carry)
    );

    // ============================================================
    // Sequencer: one clock for byte ops, two for word ops
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_reg <= BAL_IDLE;
            op_reg <= BAL_OP_SUM_REGS;
            low_saved <= BAL_BYTE_RESET;
            flags_saved <= BAL_FLAGS_RESET;
        end
        else
        begin
            case (state_reg)
                BAL_IDLE:
                    // [RULE2] word add takes a second clock
                    // [RULE5] word subtract takes a second clock
                    if (start_i && is_word_op(op_i))
                    begin
                        state_reg <= BAL_WORD_HIGH;
                        op_reg <= op_i;
                        low_saved <= wide[7:0];
                        flags_saved <= flags_i;
                    end
                BAL_WORD_HIGH:
                    state_reg <= BAL_IDLE;
                default:
                    state_reg <= BAL_IDLE;
            endcase
        end
    end

    // ============================================================
    // Registered outputs; flags held until the next completion
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            result_o <= BAL_BYTE_RESET;
            result_high_o <= BAL_BYTE_RESET;
            flags_o <= BAL_FLAGS_RESET;
            done_o <= 1'b0;
            word_o <= 1'b0;
            busy_o <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            word_o <= 1'b0;
            busy_o <= 1'b0;
            if (state_reg == BAL_WORD_HIGH)
            begin
                // [RULE2] word flags Z C N V S from 16-bit result
                result_o <= low_saved;
                result_high_o <= high_sum;
                flags_o <= flags_saved;
                flags_o[BAL_FLAG_Z] <= ({high_sum, low_saved} == 16'h0000);
                flags_o[BAL_FLAG_C] <= high_borrow;
                flags_o[BAL_FLAG_N] <= high_sum[7];
                if (is_sub(op_reg))
                begin
                    flags_o[BAL_FLAG_V] <= src_high_orig[7] & ~high_sum[7];
                    flags_o[BAL_FLAG_S] <= high_sum[7] ^
                        (src_high_orig[7] & ~high_sum[7]);
                end
                else
                begin
                    flags_o[BAL_FLAG_V] <= ~src_high_orig[7] & high_sum[7];
                    flags_o[BAL_FLAG_S] <= high_sum[7] ^
                        (~src_high_orig[7] & high_sum[7]);
                end
                done_o <= 1'b1;
                word_o <= 1'b1;
            end
            else if (start_i)
            begin
                if (is_word_op(op_i))
                    busy_o <= 1'b1;
                else
                begin
                    result_o <= result_next;
                    flags_o <= flags_next;
                    done_o <= 1'b1;
                end
            end
        end
    end

    // ============================================================
    // Checks beside the logic
    a_byte_one_clock: assert property ( // [RULE1]
        start_i && state_reg == BAL_IDLE && !is_word_op(op_i)
        |=> done_o && !word_o)
        else $error("byte op did not finish in one clock");
    a_word_two_clocks: assert property ( // [RULE2]
        start_i && state_reg == BAL_IDLE && op_i == BAL_OP_WORD_IMMEDIATE_SUM
        |=> !done_o ##1 done_o && word_o)
        else $error("word add did not take two clocks");
    a_word_sub_len: assert property ( // [RULE5]
        start_i && state_reg == BAL_IDLE &&
        op_i == BAL_OP_WORD_IMMEDIATE_DIFFERENCE
        |=> busy_o ##1 done_o)
        else $error("word subtract did not take two clocks");
    a_sub_value: assert property ( // [RULE3]
        start_i && state_reg == BAL_IDLE && op_i == BAL_OP_DIFFERENCE_CONST
        |=> result_o == $past(dst_i) - $past(src_i))
        else $error("subtract result wrong");
    a_borrow_zero: assert property ( // [RULE4]
        start_i && state_reg == BAL_IDLE &&
        op_i == BAL_OP_BORROW_DIFFERENCE_REGS && !flags_i[BAL_FLAG_Z]
        |=> !flags_o[BAL_FLAG_Z])
        else $error("borrow subtract set zero flag");
    a_and_keeps_c: assert property ( // [RULE6]
        start_i && state_reg == BAL_IDLE && op_i == BAL_OP_CONJ_REGS
        |=> flags_o[BAL_FLAG_C] == $past(flags_i[BAL_FLAG_C]))
        else $error("and changed carry");
    a_xor_value: assert property ( // [RULE7]
        start_i && state_reg == BAL_IDLE && op_i == BAL_OP_BITWISE_XOR_REGS
        |=> result_o == ($past(dst_i) ^ $past(src_i)))
        else $error("xor result wrong");
    a_mask_set: assert property ( // [RULE8]
        start_i && state_reg == BAL_IDLE && op_i == BAL_OP_SET_BITS_MASK
        |=> (result_o & $past(src_i)) == $past(src_i))
        else $error("mask bits not set");
    a_logic_flags: assert property ( // [RULE9]
        start_i && state_reg == BAL_IDLE && op_i == BAL_OP_DISJ_REGS
        |=> !flags_o[BAL_FLAG_V] && flags_o[BAL_FLAG_N] == result_o[7]
        && flags_o[BAL_FLAG_Z] == (result_o == 8'h00))
        else $error("logic flags wrong");
    a_neg_value: assert property ( // [RULE10]
        start_i && state_reg == BAL_IDLE && op_i == BAL_OP_TWOS_COMPLEMENT
        |=> result_o == 8'h00 - $past(dst_i) &&
        flags_o[BAL_FLAG_C] == ($past(dst_i) != 8'h00))
        else $error("two's complement wrong");

endmodule

// ### rtl/bal_word_stage.sv
// Word stage: holds the high byte and the low-byte carry of a word
// operation between its first and second clock.
// Assumes the main datapath supplies the captured operands.
`timescale 1ns/1ps

module bal_word_stage
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic [7:0] high_i,
    input wire logic carry_i,
    output logic [7:0] high_o,
    output logic carry_o
);
    import bal_pkg::*;

    // ============================================================
    // Captured operands, read from registers in the second clock
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            high_o <= BAL_BYTE_RESET;
            carry_o <= 1'b0;
        end
        else if (load_i)
        begin
            high_o <= high_i;
            carry_o <= carry_i;
        end
    end

endmodule

// ### shared/bal_pkg.sv
// Package for the byte arithmetic and logic unit: operation codes,
// flag bit positions, reset values and cycle counts.
// Assumes the decoder drives one operation code per request.
package bal_pkg;

    // Operation codes issued by the decoder
    typedef enum logic [3:0] {
        BAL_OP_SUM_REGS,
        BAL_OP_CARRY_SUM_REGS,
        BAL_OP_WORD_IMMEDIATE_SUM,
        BAL_OP_DIFFERENCE_REGS,
        BAL_OP_DIFFERENCE_CONST,
        BAL_OP_BORROW_DIFFERENCE_REGS,
        BAL_OP_BORROW_DIFFERENCE_CONST,
        BAL_OP_WORD_IMMEDIATE_DIFFERENCE,
        BAL_OP_CONJ_REGS,
        BAL_OP_BITWISE_CONJ_CONST,
        BAL_OP_DISJ_REGS,
        BAL_OP_BITWISE_DISJ_CONST,
        BAL_OP_BITWISE_XOR_REGS,
        BAL_OP_SET_BITS_MASK,
        BAL_OP_ONES_COMPLEMENT,
        BAL_OP_TWOS_COMPLEMENT
    } bal_op_t;

    // Flag bit positions in the 8-bit flag vector
    localparam int BAL_FLAG_C = 0;
    localparam int BAL_FLAG_Z = 1;
    localparam int BAL_FLAG_N = 2;
    localparam int BAL_FLAG_V = 3;
    localparam int BAL_FLAG_S = 4;
    localparam int BAL_FLAG_H = 5;

    // Values after reset
    localparam logic [7:0] BAL_FLAGS_RESET = 8'h00;
    localparam logic [7:0] BAL_BYTE_RESET = 8'h00;

    // Execution lengths in clocks
    localparam int BAL_BYTE_CYCLES = 1;
    localparam int BAL_WORD_CYCLES = 2;

endpackage

// ### tb/bal_alu_tb.sv
// Self-checking bench for the byte arithmetic and logic unit.
// Assumes the decoder model drives every request input of the unit.
`timescale 1ns/1ps

module bal_alu_tb;
    import bal_pkg::*;

    // ==========================================================
    // Signals and instances
    logic clk;
    logic rst_n;
    logic start;
    bal_op_t op;
    logic [7:0] dst;
    logic [7:0] dst_high;
    logic [7:0] src;
    logic [7:0] flags_in;
    logic [7:0] result;
    logic [7:0] result_high;
    logic [7:0] flags_out;
    logic done;
    logic word;
    logic busy;
    logic [7:0] exp_hi;
    int num_errors;
    int cmp_count;
    int cycles;

    bal_alu dut_u (.clk_i(clk), .rst_n_i(rst_n), .start_i(start),
        .op_i(op), .dst_i(dst), .dst_high_i(dst_high), .src_i(src),
        .flags_i(flags_in), .result_o(result), .result_high_o(result_high),
        .flags_o(flags_out), .done_o(done), .word_o(word), .busy_o(busy));

    bal_dec_model dec_u (.clk_i(clk), .busy_i(busy), .start_o(start),
        .op_o(op), .dst_o(dst), .dst_high_o(dst_high), .src_o(src),
        .flags_o(flags_in));

    // 10 MHz clock
    always #50 clk = ~clk;

    // A hang is cut short well beyond the roughly 70 cycles needed
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            num_errors++;
            test_done();
        end
    end

    // ==========================================================
    // Reference and checking helpers
    function automatic logic is_word(input bal_op_t o);
        return o == BAL_OP_WORD_IMMEDIATE_SUM
            || o == BAL_OP_WORD_IMMEDIATE_DIFFERENCE;
    endfunction

    // Returns {high, low, flags}; untouched flag bits pass through
    function automatic logic [23:0] calc(input bal_op_t o,
        input logic [7:0] a, input logic [7:0] ah, input logic [7:0] b,
        input logic [7:0] f);
        logic [16:0] w;
        logic [8:0] s;
        logic [4:0] hs;
        logic [7:0] r;
        logic [7:0] nf;
        logic sub;
        logic cin;
        logic ar;
        nf = f;
        sub = 1'b0;
        cin = 1'b0;
        ar = 1'b1;
        r = 8'h00;
        case (o)
            BAL_OP_SUM_REGS: ar = 1'b1;
            BAL_OP_CARRY_SUM_REGS: cin = f[BAL_FLAG_C];
            BAL_OP_DIFFERENCE_REGS, BAL_OP_DIFFERENCE_CONST: sub = 1'b1;
            BAL_OP_BORROW_DIFFERENCE_REGS, BAL_OP_BORROW_DIFFERENCE_CONST:
            begin
                sub = 1'b1;
                cin = f[BAL_FLAG_C];
            end
            BAL_OP_TWOS_COMPLEMENT:
            begin
                sub = 1'b1;
                b = a;
                a = 8'h00;
            end
            default: ar = 1'b0;
        endcase
        if (is_word(o))
        begin
            sub = (o == BAL_OP_WORD_IMMEDIATE_DIFFERENCE);
            w = sub ? {1'b0, ah, a} - {9'h000, b}
                : {1'b0, ah, a} + {9'h000, b};
            nf[BAL_FLAG_C] = w[16];
            nf[BAL_FLAG_N] = w[15];
            nf[BAL_FLAG_Z] = (w[15:0] == 16'h0000);
            nf[BAL_FLAG_V] = sub ? ah[7] & ~w[15] : ~ah[7] & w[15];
            nf[BAL_FLAG_S] = w[15] ^ nf[BAL_FLAG_V];
            return {w[15:0], nf};
        end
        if (ar)
        begin
            s = sub ? {1'b0, a} - {1'b0, b} - {8'h00, cin}
                : {1'b0, a} + {1'b0, b} + {8'h00, cin};
            hs = sub ? {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin}
                : {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            r = s[7:0];
            nf[BAL_FLAG_C] = s[8];
            nf[BAL_FLAG_H] = hs[4];
            nf[BAL_FLAG_V] = (a[7] ^ b[7] ^ ~sub) & (r[7] ^ a[7]);
        end
        else
        begin
            case (o)
                BAL_OP_CONJ_REGS, BAL_OP_BITWISE_CONJ_CONST: r = a & b;
                BAL_OP_BITWISE_XOR_REGS: r = a ^ b;
                BAL_OP_ONES_COMPLEMENT: r = ~a;
                default: r = a | b;
            endcase
            nf[BAL_FLAG_V] = 1'b0;
            nf[BAL_FLAG_C] = f[BAL_FLAG_C] | (o == BAL_OP_ONES_COMPLEMENT);
        end
        nf[BAL_FLAG_N] = r[7];
        nf[BAL_FLAG_Z] = (r == 8'h00);
        if (o == BAL_OP_BORROW_DIFFERENCE_REGS
            || o == BAL_OP_BORROW_DIFFERENCE_CONST)
        begin
            nf[BAL_FLAG_Z] = nf[BAL_FLAG_Z] & f[BAL_FLAG_Z];
        end
        return {8'h00, r, nf};
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
        input string what);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One request, its latency counted in edges after the taking edge
    task automatic run(input bal_op_t o, input logic [7:0] d,
        input logic [7:0] h, input logic [7:0] s, input logic [7:0] f,
        input logic keep);
        logic [23:0] e;
        int n;
        logic wd;
        wd = is_word(o);
        e = calc(o, d, h, s, f);
        dec_u.issue(o, d, h, s, f, keep);
        n = 0;
        if (wd)
        begin
            chk({7'h00, busy}, 8'h01, "busy");
        end
        while (done !== 1'b1 && n < 4)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(8'(n), 8'(wd ? BAL_WORD_CYCLES - 1 : BAL_BYTE_CYCLES - 1), "lat");
        chk({7'h00, word}, {7'h00, wd}, "word pulse");
        if (wd)
        begin
            exp_hi = e[23:16];
        end
        chk(result, e[15:8], "result");
        chk(result_high, exp_hi, "high byte");
        chk(flags_out, e[7:0], "flags");
        // A dropped strobe gets an edge of its own before the next request
        if (!keep)
        begin
            @(posedge clk);
            #1;
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        rst_n = 1'b0;
        repeat (16) @(posedge clk);
        #1;
        chk({done, word, busy, 5'h00} | result | result_high | flags_out,
            8'h00, "outputs in reset");
        rst_n = 1'b1;
        @(posedge clk);
        #1;
        chk({done, word, busy, 5'h00} | result | result_high | flags_out,
            8'h00, "outputs after reset");
        $display("test reset done");
    endtask

    // Overflow, carry and half-carry edges; sign flag must survive
    task automatic t_add();
        run(BAL_OP_SUM_REGS, 8'h7F, 8'h00, 8'h01, 8'h10, 1'b0);
        run(BAL_OP_SUM_REGS, 8'hFF, 8'h00, 8'h01, 8'h10, 1'b0);
        run(BAL_OP_CARRY_SUM_REGS, 8'hFF, 8'h00, 8'h00, 8'h01,
            1'b0);
        run(BAL_OP_CARRY_SUM_REGS, 8'h80, 8'h00, 8'h80, 8'h00,
            1'b0);
        $display("test add done");
    endtask

    // Borrow cases, zero flag chained through borrow subtracts
    task automatic t_sub();
        run(BAL_OP_DIFFERENCE_REGS, 8'h00, 8'h00, 8'h01, 8'h00,
            1'b1);
        run(BAL_OP_DIFFERENCE_CONST, 8'h80, 8'h00, 8'h01, 8'h00,
            1'b0);
        run(BAL_OP_BORROW_DIFFERENCE_REGS, 8'h01, 8'h00, 8'h00, 8'h03,
            1'b1);
        run(BAL_OP_BORROW_DIFFERENCE_CONST, 8'h01, 8'h00, 8'h00, 8'h01,
            1'b1);
        run(BAL_OP_BORROW_DIFFERENCE_CONST, 8'h05, 8'h00, 8'h03, 8'h03,
            1'b0);
        // Zero result with old Z clear must leave Z clear
        run(BAL_OP_BORROW_DIFFERENCE_REGS, 8'h01, 8'h00, 8'h00, 8'h01,
            1'b0);
        $display("test subtract done");
    endtask

    // Logic ops back to back; carry and half-carry left alone
    task automatic t_logic();
        run(BAL_OP_CONJ_REGS, 8'hF0, 8'h00, 8'h0F, 8'h29, 1'b1);
        run(BAL_OP_BITWISE_CONJ_CONST, 8'hC3, 8'h00, 8'h81, 8'h29,
            1'b1);
        run(BAL_OP_DISJ_REGS, 8'h00, 8'h00, 8'h00, 8'h2B, 1'b1);
        run(BAL_OP_BITWISE_DISJ_CONST, 8'h80, 8'h00, 8'h01, 8'h29,
            1'b1);
        run(BAL_OP_BITWISE_XOR_REGS, 8'hAA, 8'h00, 8'hAA, 8'h08,
            1'b1);
        run(BAL_OP_SET_BITS_MASK, 8'h01, 8'h00, 8'h80, 8'h2F, 1'b0);
        $display("test logic done");
    endtask

    task automatic t_compl();
        run(BAL_OP_ONES_COMPLEMENT, 8'h00, 8'h00, 8'h00, 8'h08,
            1'b0);
        run(BAL_OP_TWOS_COMPLEMENT, 8'h01, 8'h00, 8'h00, 8'h00,
            1'b0);
        run(BAL_OP_TWOS_COMPLEMENT, 8'h80, 8'h00, 8'h00, 8'h00,
            1'b0);
        run(BAL_OP_TWOS_COMPLEMENT, 8'h00, 8'h00, 8'h00, 8'h01,
            1'b0);
        $display("test complement done");
    endtask

    // Word boundaries, a strobe refused mid-op, high byte then held
    task automatic t_word();
        run(BAL_OP_WORD_IMMEDIATE_SUM, 8'hFF, 8'h00, 8'h01, 8'h00,
            1'b0);
        run(BAL_OP_WORD_IMMEDIATE_SUM, 8'hFF, 8'h7F, 8'h01, 8'h00,
            1'b0);
        run(BAL_OP_WORD_IMMEDIATE_DIFFERENCE, 8'h00, 8'h00, 8'h01, 8'h00,
            1'b0);
        run(BAL_OP_WORD_IMMEDIATE_DIFFERENCE, 8'h00, 8'h80, 8'h01, 8'h00,
            1'b0);
        run(BAL_OP_WORD_IMMEDIATE_SUM, 8'h10, 8'h20, 8'h05, 8'h00,
            1'b1);
        dec_u.idle();
        @(posedge clk);
        #1;
        // A strobe held into the second clock must start nothing new
        chk({7'h00, done}, 8'h00, "refused strobe");
        chk({7'h00, busy}, 8'h00, "refused strobe busy");
        run(BAL_OP_SUM_REGS, 8'h01, 8'h55, 8'h02, 8'h00, 1'b0);
        $display("test word done");
    endtask

    // ==========================================================
    // Main sequence and verdict
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
        begin
            $display("Testbench passed");
        end
        else
        begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        exp_hi = 8'h00;
        num_errors = 0;
        cmp_count = 0;
        cycles = 0;
        t_reset();
        t_add();
        t_sub();
        t_logic();
        t_compl();
        t_word();
        test_done();
    end
endmodule

// ### tb/bal_dec_model.sv
// Stand-in for the instruction decoder and register file of the unit.
// Assumes its tasks are entered just after a rising clock edge.
`timescale 1ns/1ps

module bal_dec_model
(
    input wire logic clk_i,
    input wire logic busy_i,
    output logic start_o,
    output bal_pkg::bal_op_t op_o,
    output logic [7:0] dst_o,
    output logic [7:0] dst_high_o,
    output logic [7:0] src_o,
    output logic [7:0] flags_o
);
    import bal_pkg::*;

    // ==========================================================
    // Request driving
    // Idle at time zero
    initial
    begin
        start_o = 1'b0;
        op_o = BAL_OP_SUM_REGS;
        {dst_o, dst_high_o, src_o, flags_o} = 32'h0000_0000;
    end

    // Drop the strobe; operands flip so a stale copy is never reused
    task automatic idle();
        start_o = 1'b0;
        dst_o = ~dst_o;
        dst_high_o = ~dst_high_o;
        src_o = ~src_o;
        flags_o = ~flags_o;
    endtask

    // Hold a request through its taking edge; keep leaves the strobe up
    task automatic issue(input bal_op_t op, input logic [7:0] d,
        input logic [7:0] h, input logic [7:0] s, input logic [7:0] f,
        input logic keep);
        while (busy_i === 1'b1)
        begin
            @(posedge clk_i);
            #1;
        end
        start_o = 1'b1;
        op_o = op;
        dst_o = d;
        dst_high_o = h;
        src_o = s;
        flags_o = f;
        @(posedge clk_i);
        #1;
        if (!keep)
        begin
            idle();
        end
    endtask
endmodule
